// ==== verilog/rac_pkg.sv ====
// Purpose : shared constants for the relay alarm output control block
// Assumes : 40 MHz mclk_i, time parameters in 0.1 s units
// Notes   : source and mode encodings are used by the top and the testbench
package rac_pkg;
   // clock and time base
   localparam int unsigned CLK_PERIOD_PS = 25000;          // 40 MHz
   localparam longint     TICK_TIME_PS  = 64'h174876E800;   // 0.1 s in ps
   localparam int unsigned TICK_CYCLES   = int'(TICK_TIME_PS / CLK_PERIOD_PS);
   // default sizes
   localparam int unsigned MEAS_W     = 16;
   localparam int unsigned TIME_W     = 16;
   localparam int unsigned NUM_CH     = 4;
   localparam int unsigned NUM_OUT    = 2;
   // per-channel source selection
   typedef enum logic [1:0] {
      RAC_SRC_NONE = 2'h0,
      RAC_SRC_AL1  = 2'h1,
      RAC_SRC_AL2  = 2'h2,
      RAC_SRC_BOTH = 2'h3
   } rac_src_t;
   // alarm direction and output mode / logic function bits
   localparam logic DIR_UNDER = 1'h0;
   localparam logic DIR_OVER  = 1'h1;
   localparam logic MODE_NO   = 1'h0;
   localparam logic MODE_NC   = 1'h1;
   localparam logic FUNC_OR   = 1'h0;
   localparam logic FUNC_AND  = 1'h1;
   // reset values
   localparam logic RST_ALARM = 1'h0;
endpackage

// ==== verilog/rac_ch_if.sv ====
// Purpose : carries one channel's measurement, alarm settings and alarm states
// Assumes : all signals in the mclk_i domain
// Notes   : src side is the top, det side is the alarm detector
`timescale 1ns/1ps
interface rac_ch_if #(parameter int unsigned W = 16);
   logic signed [W-1:0] meas;
   logic signed [W-1:0] thr1;
   logic signed [W-1:0] hyst1;
   logic signed [W-1:0] thr2;
   logic signed [W-1:0] hyst2;
   logic                dir1;
   logic                dir2;
   logic                al1;
   logic                al2;
   modport src (output meas, thr1, hyst1, thr2, hyst2, dir1, dir2, input al1, al2);
   modport det (input meas, thr1, hyst1, thr2, hyst2, dir1, dir2, output al1, al2);
endinterface

// ==== verilog/rac_alarm.sv ====
// Purpose : two independent hysteresis alarms for one measurement channel
// Assumes : measurement and settings come from logic on mclk_i
// Notes   : bounds are computed one bit wider so threshold +/- hysteresis never wraps
`timescale 1ns/1ps
module rac_alarm
   import rac_pkg::*;
#(
   parameter int unsigned W = rac_pkg::MEAS_W
)(
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // channel
   rac_ch_if.det     ch
);
   import rac_pkg::*;

   logic al1_q, al1_d, al2_q, al2_d;

   // one hysteresis step: set at the far edge of the band, clear at the near edge
   function automatic logic alarm_next(input logic cur, input logic over,
                                       input logic signed [W-1:0] m,
                                       input logic signed [W-1:0] t,
                                       input logic signed [W-1:0] h);
      logic signed [W:0] hi;
      logic signed [W:0] lo;
      logic signed [W:0] mx;
      hi = $signed({t[W-1], t}) + $signed({h[W-1], h});
      lo = $signed({t[W-1], t}) - $signed({h[W-1], h});
      mx = $signed({m[W-1], m});
      if (over == DIR_OVER) begin
         alarm_next = cur ? (mx > lo) : (mx >= hi);   // see R7
      end else begin
         alarm_next = cur ? (mx < hi) : (mx <= lo);   // see R6
      end
   endfunction

   // next alarm states, both alarms evaluated independently
   always_comb begin
      al1_d = alarm_next(al1_q, ch.dir1, ch.meas, ch.thr1, ch.hyst1);   // see R8
      al2_d = alarm_next(al2_q, ch.dir2, ch.meas, ch.thr2, ch.hyst2);   // see R8
   end

   // alarm state registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         al1_q <= RST_ALARM;
         al2_q <= RST_ALARM;
      end else begin
         al1_q <= al1_d;
         al2_q <= al2_d;
      end
   end

   assign ch.al1 = al1_q;
   assign ch.al2 = al2_q;

   // over mode: reaching threshold plus hysteresis raises the alarm
   a_over_set: assert property (@(posedge mclk_i) disable iff (rst_i) // see R7
      (ch.dir1 == DIR_OVER && $signed({ch.meas[W-1], ch.meas}) >=
       $signed({ch.thr1[W-1], ch.thr1}) + $signed({ch.hyst1[W-1], ch.hyst1}))
      |=> al1_q) else $error("over alarm not raised at upper bound");
   // under mode: reaching threshold minus hysteresis raises the alarm
   a_under_set: assert property (@(posedge mclk_i) disable iff (rst_i) // see R6
      (ch.dir2 == DIR_UNDER && $signed({ch.meas[W-1], ch.meas}) <=
       $signed({ch.thr2[W-1], ch.thr2}) - $signed({ch.hyst2[W-1], ch.hyst2}))
      |=> al2_q) else $error("under alarm not raised at lower bound");
   c_alarm_rise: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(al1_q));
endmodule

// ==== verilog/rac_top.sv ====
// Purpose : relay outputs driven by combined channel alarms with delay and hold timing
// Assumes : 40 MHz mclk_i; settings and measurements are synchronous to mclk_i
// Notes   : delay and hold values are counts of 0.1 s ticks; TICK_CYC shortens in simulation
`timescale 1ns/1ps

// Functional notes
// R1: after the relay changes, it keeps the new state for at least the closed or open hold time.
// R1 here: hold can end up to one tick early; a mode_nc_i change moves the relay.
// R2: while a hold runs, alarms are ignored and the delay counter does not move.
// R3: the delay counter counts up on each tick with a combined result of 1.
// R4: the delay counter counts down on each tick with a combined result of 0, stopping at 0.
// R5: the relay changes only once the counter reaches the close or open delay.
// R6: under mode raises the alarm at threshold minus hysteresis, clears at threshold plus.
// R7: over mode raises the alarm at threshold plus hysteresis, clears at threshold minus.
// R8: each channel has two alarms; the source picks alarm 1, alarm 2 or both per channel.
// R9: the combining function is OR of attached channels or AND of all attached channels.
// R10: normally open closes the relay on a filtered 1; normally closed inverts that.
// R11: a delay of zero switches as soon as the condition appears, without counting.
// R12: delay and hold timers count 0.1 s ticks made from the system clock.
module rac_top
   import rac_pkg::*;
#(
   parameter int unsigned NCH      = rac_pkg::NUM_CH,
   parameter int unsigned NOUT     = rac_pkg::NUM_OUT,
   parameter int unsigned W        = rac_pkg::MEAS_W,
   parameter int unsigned TW       = rac_pkg::TIME_W,
   parameter int unsigned TICK_CYC = rac_pkg::TICK_CYCLES
)(
   // clock and reset
   input  wire logic                            mclk_i,
   input  wire logic                            rst_i,
   // measurements and alarm settings, per channel
   input  wire logic signed [NCH-1:0][W-1:0]    meas_i,
   input  wire logic signed [NCH-1:0][W-1:0]    thr1_i,
   input  wire logic signed [NCH-1:0][W-1:0]    hyst1_i,
   input  wire logic signed [NCH-1:0][W-1:0]    thr2_i,
   input  wire logic signed [NCH-1:0][W-1:0]    hyst2_i,
   input  wire logic        [NCH-1:0]           first_alarm_direction_i,
   input  wire logic        [NCH-1:0]           second_alarm_direction_i,
   // output settings, per relay
   input  wire logic        [NOUT-1:0][NCH-1:0][1:0] src_sel_i,
   input  wire logic        [NOUT-1:0]          logic_and_i,
   input  wire logic        [NOUT-1:0]          mode_nc_i,
   input  wire logic        [NOUT-1:0][TW-1:0]  close_delay_i,
   input  wire logic        [NOUT-1:0][TW-1:0]  open_delay_i,
   input  wire logic        [NOUT-1:0][TW-1:0]  closed_hold_i,
   input  wire logic        [NOUT-1:0][TW-1:0]  open_hold_i,
   // status and relays
   output logic             [NCH-1:0]           alarm1_o,
   output logic             [NCH-1:0]           alarm2_o,
   output logic             [NOUT-1:0]          relay_closed_o
);
   import rac_pkg::*;

   localparam int unsigned PW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);

   logic [PW-1:0] pre_q, pre_d;
   logic          tick_q, tick_d;
   logic [NCH-1:0] al1, al2;

   // 0.1 s time base; one-cycle tick registered so timers see a clean strobe
   always_comb begin
      pre_d  = (pre_q == PRE_LAST) ? '0 : pre_q + PW'(1);   // see R12
      tick_d = (pre_q == PRE_LAST);                          // see R12
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pre_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         tick_q <= tick_d;
      end
   end

   // per-channel alarm detectors
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         rac_ch_if #(.W(W)) chi ();
         assign chi.meas  = meas_i[c];
         assign chi.thr1  = thr1_i[c];
         assign chi.hyst1 = hyst1_i[c];
         assign chi.thr2  = thr2_i[c];
         assign chi.hyst2 = hyst2_i[c];
         assign chi.dir1  = first_alarm_direction_i[c];
         assign chi.dir2  = second_alarm_direction_i[c];
         assign al1[c]    = chi.al1;
         assign al2[c]    = chi.al2;
         rac_alarm #(.W(W)) u_alarm (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .ch     (chi.det)
         );
      end
   endgenerate

   // alarm states come straight from the detector flops
   assign alarm1_o = al1;
   assign alarm2_o = al2;

   // channel condition selected by the source setting
   function automatic logic chan_cond(input logic [1:0] sel, input logic a1, input logic a2);
      case (sel)
         RAC_SRC_AL1:  chan_cond = a1;
         RAC_SRC_AL2:  chan_cond = a2;
         RAC_SRC_BOTH: chan_cond = a1 & a2;
         default:      chan_cond = 1'b0;
      endcase
   endfunction

   // combined logic: unattached channels take no part; AND with none attached is 0
   function automatic logic combine(input logic [NCH-1:0][1:0] sel, input logic fand,
                                    input logic [NCH-1:0] a1, input logic [NCH-1:0] a2);
      logic any_c;
      logic all_c;
      logic att;
      any_c = 1'b0;
      all_c = 1'b1;
      att   = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         if (sel[c] != RAC_SRC_NONE) begin
            att   = 1'b1;
            any_c = any_c | chan_cond(sel[c], a1[c], a2[c]);   // see R8
            all_c = all_c & chan_cond(sel[c], a1[c], a2[c]);   // see R8
         end
      end
      combine = (fand == FUNC_AND) ? (att & all_c) : any_c;    // see R9
   endfunction

   logic [NOUT-1:0]         lf;
   logic [NOUT-1:0]         filt_q, filt_d;
   logic [NOUT-1:0]         relay_q, relay_d;
   logic [NOUT-1:0][TW-1:0] cnt_q, cnt_d;
   logic [NOUT-1:0][TW-1:0] hold_q, hold_d;

   // delay counter, hold timer and relay state per output
   always_comb begin
      for (int o = 0; o < NOUT; o++) begin
         lf[o]      = combine(src_sel_i[o], logic_and_i[o], al1, al2);
         filt_d[o]  = filt_q[o];
         cnt_d[o]   = cnt_q[o];
         hold_d[o]  = hold_q[o];
         relay_d[o] = relay_q[o];
         if (hold_q[o] != '0) begin
            // alarms ignored while holding; only the hold timer runs
            if (tick_q) begin
               hold_d[o] = hold_q[o] - TW'(1);                  // see R1, R2
            end
         end else if (!filt_q[o]) begin
            // open side: count toward the close delay
            if (lf[o] && close_delay_i[o] == '0) begin
               filt_d[o] = 1'b1;                                // see R11
               cnt_d[o]  = open_delay_i[o];
            end else if (tick_q && lf[o]) begin
               if (cnt_q[o] + TW'(1) >= close_delay_i[o]) begin
                  filt_d[o] = 1'b1;                             // see R5
                  cnt_d[o]  = open_delay_i[o];
               end else begin
                  cnt_d[o] = cnt_q[o] + TW'(1);                 // see R3
               end
            end else if (tick_q && cnt_q[o] != '0) begin
               cnt_d[o] = cnt_q[o] - TW'(1);                    // see R4
            end
         end else begin
            // closed side: counter starts at the open delay and falls on 0
            if (!lf[o] && open_delay_i[o] == '0) begin
               filt_d[o] = 1'b0;                                // see R11
               cnt_d[o]  = '0;
            end else if (tick_q && !lf[o]) begin
               if (cnt_q[o] <= TW'(1)) begin
                  filt_d[o] = 1'b0;                             // see R5
                  cnt_d[o]  = '0;
               end else begin
                  cnt_d[o] = cnt_q[o] - TW'(1);                 // see R4
               end
            end else if (tick_q && cnt_q[o] < open_delay_i[o]) begin
               cnt_d[o] = cnt_q[o] + TW'(1);                    // see R3
            end
         end
         relay_d[o] = filt_d[o] ^ (mode_nc_i[o] == MODE_NC);    // see R10
         if (relay_d[o] != relay_q[o]) begin
            hold_d[o] = relay_d[o] ? closed_hold_i[o] : open_hold_i[o];   // see R1
         end
      end
   end

   // a reset relay is open in normally-open mode; first clock applies the mode
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         filt_q  <= '0;
         relay_q <= '0;
         cnt_q   <= '0;
         hold_q  <= '0;
      end else begin
         filt_q  <= filt_d;
         relay_q <= relay_d;
         cnt_q   <= cnt_d;
         hold_q  <= hold_d;
      end
   end

   assign relay_closed_o = relay_q;

   // checks, per output
   generate
      for (genvar o = 0; o < NOUT; o++) begin : g_chk
         a_hold_freeze: assert property (@(posedge mclk_i) disable iff (rst_i) // see R1
            (hold_q[o] != '0 && $stable(mode_nc_i[o])) |=> $stable(relay_q[o]))
            else $error("relay moved during hold");
         a_hold_load: assert property (@(posedge mclk_i) disable iff (rst_i) // see R1
            (relay_q[o] != $past(relay_q[o])) |->
            hold_q[o] == (relay_q[o] ? $past(closed_hold_i[o]) : $past(open_hold_i[o])))
            else $error("hold time not loaded on relay change");
         a_cnt_freeze: assert property (@(posedge mclk_i) disable iff (rst_i) // see R2
            hold_q[o] != '0 |=> cnt_q[o] == $past(cnt_q[o]))
            else $error("delay counter moved during hold");
         a_cnt_up: assert property (@(posedge mclk_i) disable iff (rst_i) // see R3
            (hold_q[o] == '0 && tick_q && lf[o] && !filt_q[o] &&
             cnt_q[o] + TW'(1) < close_delay_i[o]) |=> cnt_q[o] == $past(cnt_q[o]) + TW'(1))
            else $error("delay counter did not count up");
         a_cnt_down: assert property (@(posedge mclk_i) disable iff (rst_i) // see R4
            (hold_q[o] == '0 && tick_q && !lf[o] && !filt_q[o] && cnt_q[o] != '0)
            |=> cnt_q[o] == $past(cnt_q[o]) - TW'(1))
            else $error("delay counter did not count down");
         a_close_delay: assert property (@(posedge mclk_i) disable iff (rst_i) // see R5
            ($rose(filt_q[o]) && $past(close_delay_i[o]) != '0) |->
            ($past(tick_q) && $past(cnt_q[o]) + TW'(1) >= $past(close_delay_i[o])))
            else $error("closed before delay reached");
         a_zero_delay: assert property (@(posedge mclk_i) disable iff (rst_i) // see R11
            (hold_q[o] == '0 && !filt_q[o] && lf[o] && close_delay_i[o] == '0) |=> filt_q[o])
            else $error("zero delay did not switch at once");
         a_mode_map: assert property (@(posedge mclk_i) disable iff (rst_i) // see R10
            $stable(mode_nc_i[o]) && $stable(filt_q[o]) && hold_q[o] == '0
            |=> relay_q[o] == (filt_q[o] ^ mode_nc_i[o]))
            else $error("relay does not follow mode");
         c_close: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(relay_q[o]));
         c_hold: cover property (@(posedge mclk_i) disable iff (rst_i)
            hold_q[o] != '0 && lf[o] != filt_q[o]);
         c_delay: cover property (@(posedge mclk_i) disable iff (rst_i)
            $fell(filt_q[o]) && $past(open_delay_i[o]) > TW'(1));
      end
   endgenerate
endmodule

// ==== tb/rac_load_model.sv ====
// Purpose : external load switched by one relay contact of the alarm output block
// Assumes : contact state is sampled on mclk_i, no contact bounce
// Notes   : counts contact operations so the bench can spot chatter on the relay
`timescale 1ns/1ps
module rac_load_model (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // contact and load state
   input  wire logic contact_closed_i,
   output logic      energized_o,
   output int        switch_cnt_o
);
   logic last_q;

   // the load is powered exactly while the contact is closed
   assign energized_o = contact_closed_i;

   // count every change of the contact; a chattering relay shows up as extra counts
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         switch_cnt_o <= 0;
      end else if (contact_closed_i != last_q) begin
         switch_cnt_o <= switch_cnt_o + 1;
      end
      last_q <= contact_closed_i;
   end
endmodule

// ==== tb/testbench.sv ====
// Purpose : self-checking bench for the relay alarm output block
// Assumes : short tick of TK clocks; inputs change on the falling edge
// Notes   : random batches run with zero delays and holds, timed cases are hand-written
`timescale 1ns/1ps
module testbench;
   import rac_pkg::*;
   localparam int TK = 4;
   localparam int NC = NUM_CH;
   localparam int NO = NUM_OUT;
   logic                             mclk_i;
   logic                             rst_i;
   logic signed [NC-1:0][MEAS_W-1:0] meas_i, thr1_i, hyst1_i, thr2_i, hyst2_i;
   logic        [NC-1:0]             dir1, dir2, alarm1_o, alarm2_o, exp_a1, exp_a2;
   logic        [NO-1:0][NC-1:0][1:0] src_sel_i;
   logic        [NO-1:0]             logic_and_i, mode_nc_i, relay_closed_o, load_on, exp_rel;
   logic        [NO-1:0][TIME_W-1:0] cdly, odly, chold, ohold;
   logic        [31:0]               r;
   int                               n_errors, n_compared, n, tph;
   integer                           seed = 32'hD28D;
   int                               cyc = 0;
   int                               sw_cnt [NO];

   rac_top #(.TICK_CYC(TK)) uut (.mclk_i(mclk_i), .rst_i(rst_i), .meas_i(meas_i),
      .thr1_i(thr1_i), .hyst1_i(hyst1_i), .thr2_i(thr2_i), .hyst2_i(hyst2_i),
      .first_alarm_direction_i(dir1), .second_alarm_direction_i(dir2),
      .src_sel_i(src_sel_i), .logic_and_i(logic_and_i), .mode_nc_i(mode_nc_i),
      .close_delay_i(cdly), .open_delay_i(odly), .closed_hold_i(chold), .open_hold_i(ohold),
      .alarm1_o(alarm1_o), .alarm2_o(alarm2_o), .relay_closed_o(relay_closed_o));

   // one load per relay
   for (genvar g = 0; g < NO; g++) begin : g_load
      rac_load_model u_load (.mclk_i(mclk_i), .rst_i(rst_i),
         .contact_closed_i(relay_closed_o[g]), .energized_o(load_on[g]),
         .switch_cnt_o(sw_cnt[g]));
   end

   // 40 MHz clock and an edge counter used to find the tick phase
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) cyc <= cyc + 1;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // hysteresis alarm: equal bounds never occur here since hysteresis is at least 1
   function automatic logic nxt(input logic dir, input logic prev,
                                input logic signed [MEAS_W-1:0] m, t, h);
      if (dir == DIR_OVER)
         return (m >= t + h) ? 1'b1 : ((m <= t - h) ? 1'b0 : prev);
      return (m <= t - h) ? 1'b1 : ((m >= t + h) ? 1'b0 : prev);
   endfunction

   // combined condition of one output from the expected alarm states
   function automatic logic comb(input int o);
      int   att = 0;
      int   hit = 0;
      logic c;
      for (int k = 0; k < NC; k++) begin
         case (src_sel_i[o][k])
            RAC_SRC_AL1: c = exp_a1[k];
            RAC_SRC_AL2: c = exp_a2[k];
            default:     c = exp_a1[k] & exp_a2[k];
         endcase
         if (src_sel_i[o][k] != RAC_SRC_NONE) begin
            att++;
            hit += int'(c);
         end
      end
      if (logic_and_i[o] == FUNC_AND)
         return (att != 0) && (hit == att);
      return hit != 0;
   endfunction

   task automatic do_reset(input int cycles);
      rst_i = 1'b1;
      repeat (cycles) @(negedge mclk_i);
      rst_i = 1'b0;
      exp_a1 = '0;
      exp_a2 = '0;
      exp_rel = '0;
   endtask

   // update the expectation at the rising edge, return on the next falling edge
   task automatic step();
      @(posedge mclk_i);
      for (int o = 0; o < NO; o++)
         exp_rel[o] = comb(o) ^ mode_nc_i[o];
      for (int k = 0; k < NC; k++) begin
         exp_a1[k] = nxt(dir1[k], exp_a1[k], meas_i[k], thr1_i[k], hyst1_i[k]);
         exp_a2[k] = nxt(dir2[k], exp_a2[k], meas_i[k], thr2_i[k], hyst2_i[k]);
      end
      @(negedge mclk_i);
   endtask

   task automatic wait_rel(input int o, input logic v);
      n = 0;
      while (load_on[o] !== v && n < 8 * TK) begin
         @(negedge mclk_i);
         n++;
      end
   endtask

   // wait until the last rising edge was a tick edge
   task automatic align();
      while (cyc % TK != tph) @(negedge mclk_i);
   endtask

   initial begin
      rst_i = 1'b1;
      {meas_i, thr1_i, hyst1_i, thr2_i, hyst2_i, dir1, dir2} = '0;
      {src_sel_i, logic_and_i, mode_nc_i, cdly, odly, chold, ohold} = '0;
      @(negedge mclk_i);
      do_reset(10);
      // random batches: every function and mode on each output, zero delays and holds
      for (int b = 0; b < 8; b++) begin
         for (int k = 0; k < NC; k++) begin
            thr1_i[k] = MEAS_W'($random(seed) % 40);
            thr2_i[k] = thr1_i[k] + MEAS_W'($random(seed) % 3);
            hyst1_i[k] = MEAS_W'(1 + ($random(seed) & 3));
            hyst2_i[k] = MEAS_W'(1 + ($random(seed) & 3));
         end
         r = $random(seed);
         dir1 = r[NC-1:0];
         dir2 = r[2*NC-1:NC];
         r = $random(seed);
         src_sel_i = r[NO*NC*2-1:0];
         logic_and_i = NO'(b);
         mode_nc_i = NO'(b >> 1);
         do_reset(2);
         for (int i = 0; i < 150; i++) begin
            chk(alarm1_o, exp_a1, "first alarm");
            chk(alarm2_o, exp_a2, "second alarm");
            if (i >= 3)
               chk(relay_closed_o, exp_rel, "relay");
            for (int k = 0; k < NC; k++)
               meas_i[k] = thr1_i[k] + MEAS_W'($random(seed) % 7);
            step();
         end
         $display("random batch %0d done", b);
      end
      // timed cases: out0 delayed by ch0, out1 zero delay with closed hold by ch1
      {meas_i, src_sel_i, logic_and_i, mode_nc_i, cdly, odly, chold, ohold} = '0;
      for (int k = 0; k < NC; k++) begin
         thr1_i[k] = MEAS_W'(100);
         hyst1_i[k] = MEAS_W'(2);
      end
      dir1 = '1;
      src_sel_i[0][0] = RAC_SRC_AL1;
      src_sel_i[1][1] = RAC_SRC_AL1;
      cdly[0] = TIME_W'(3);
      odly[0] = TIME_W'(2);
      chold[1] = TIME_W'(3);
      do_reset(2);
      repeat (3) @(negedge mclk_i);
      meas_i[0] = MEAS_W'(200);
      wait_rel(0, 1'b1);
      chk(n >= 2 * TK + 1 && n <= 3 * TK + 2, 1, "close delay");
      tph = (cyc - 1) % TK;
      align();
      meas_i[0] = MEAS_W'(0);
      wait_rel(0, 1'b0);
      chk(n >= 2 * TK && n <= 2 * TK + 2, 1, "open delay");
      // counter goes up two ticks, down one, then needs two more to close
      align();
      meas_i[0] = MEAS_W'(200);
      repeat (2 * TK) @(negedge mclk_i);
      chk(load_on[0], 1'b0, "early close");
      meas_i[0] = MEAS_W'(0);
      repeat (TK) @(negedge mclk_i);
      chk(load_on[0], 1'b0, "early close");
      meas_i[0] = MEAS_W'(200);
      wait_rel(0, 1'b1);
      chk(n >= 2 * TK && n <= 2 * TK + 2, 1, "up down count");
      $display("delay counter test done");
      // zero delay closes at once, the closed hold keeps it despite the alarm going away
      align();
      meas_i[1] = MEAS_W'(200);
      wait_rel(1, 1'b1);
      chk(n >= 1 && n <= 2, 1, "zero delay");
      meas_i[1] = MEAS_W'(0);
      wait_rel(1, 1'b0);
      chk(n >= 2 * TK && n <= 3 * TK + 2, 1, "closed hold");
      // the load counts a contact change at the edge after the relay moves
      @(negedge mclk_i);
      chk(sw_cnt[1], 2, "load operations");
      $display("hold test done");
      stop_test();
   end

   // watchdog, far beyond the roughly 1300 cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk_i);
      n_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule
